// ===== hw/irq_ctrl_consts.svh
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH
// Register addresses of the block.
`define ADDR_FLAGS_FIRST 8'h00
`define ADDR_FLAGS_SECOND 8'h01
`define ADDR_ENABLE_FIRST 8'h02
`define ADDR_ENABLE_SECOND 8'h03
`define ADDR_GENERAL_STATUS 8'h04
`define ADDR_FIFO_THRESHOLD 8'h05
// Field positions in the first flag register.
`define BIT_TRANSMIT_DONE 0
`define BIT_RECEIVE_DONE 1
`define BIT_COMMAND_IDLE 2
`define BIT_FIFO_HIGH 3
`define BIT_FIFO_LOW 4
`define BIT_RECEIVE_ERROR 5
`define BIT_FRAME_START 6
`define BIT_CARD_DETECT 7
// Field positions in the second flag register.
`define BIT_ANY_SOURCE 6
`define BIT_SET_MODE 7
// Reset values.
`define RESET_FLAGS 8'h00
`define RESET_ENABLE 8'h00
`define RESET_THRESHOLD 9'h008
`endif

// ===== hw/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
  // Width of one register.
  typedef logic [7:0] reg_byte_t;
endpackage : irq_ctrl_pkg

// ===== hw/nfc_irq_ctrl.sv
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "irq_ctrl_consts.svh"
module nfc_irq_ctrl #(
  parameter int FIFO_AW = 9
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] timer_underflow,
  input wire logic tx_payload_done,
  input wire logic rx_data_end,
  input wire logic command_finished,
  input wire logic [FIFO_AW:0] fifo_fill,
  input wire logic [7:0] error_bits,
  input wire logic card_detected,
  input wire logic rx_frame_start,
  output logic irq_out
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  irq_ctrl_pkg::reg_byte_t flags_first_q;   // First flag register.
  irq_ctrl_pkg::reg_byte_t flags_second_q;  // Second flag register.
  irq_ctrl_pkg::reg_byte_t enable_first_q;  // First enable register.
  irq_ctrl_pkg::reg_byte_t enable_second_q; // Second enable register.
  logic [8:0] fifo_threshold_q;              // Threshold with extension in bit 8.
  logic fifo_high_status_q;                  // Previous high status.
  logic fifo_low_status_q;                   // Previous low status.
  logic status_irq_q;                        // Sticky status bit, cleared on read.
  logic [7:0] ev_first;                      // Hardware events, first register.
  logic [7:0] ev_second;                     // Hardware events, second register.
  logic fifo_high_status;                    // Fill reached upper level.
  logic fifo_low_status;                     // Fill reached lower level.
  logic any_enabled;                         // Some enabled source is active.
  logic wr_first;                            // Write to first flag register.
  logic wr_second;                           // Write to second flag register.
  logic [FIFO_AW:0] top_level;               // Upper warning level.

  // ----------------------------------------------------------------
  // FIFO levels
  // ----------------------------------------------------------------
  // The upper level counts down from the buffer top, the lower one up.
  assign top_level = (FIFO_AW + 1)'(1 << FIFO_AW) - (FIFO_AW + 1)'(fifo_threshold_q);
  assign fifo_high_status = fifo_fill >= top_level;
  assign fifo_low_status = fifo_fill <= (FIFO_AW + 1)'(fifo_threshold_q);

  // ----------------------------------------------------------------
  // Event gathering
  // ----------------------------------------------------------------
  // Each source raises a one-cycle event into its flag position.
  always_comb begin
    ev_first = 8'h00;
    ev_first[`BIT_TRANSMIT_DONE] = tx_payload_done;
    ev_first[`BIT_RECEIVE_DONE] = rx_data_end;
    ev_first[`BIT_COMMAND_IDLE] = command_finished;
    ev_first[`BIT_FIFO_HIGH] = fifo_high_status & ~fifo_high_status_q;
    ev_first[`BIT_FIFO_LOW] = fifo_low_status & ~fifo_low_status_q;
    ev_first[`BIT_RECEIVE_ERROR] = |error_bits;
    ev_first[`BIT_FRAME_START] = rx_frame_start;
    ev_first[`BIT_CARD_DETECT] = card_detected;
    ev_second = {4'h0, timer_underflow};
  end

  // Global flag tracks any enabled source other than itself.
  assign any_enabled = |(flags_first_q & enable_first_q) |
    |(flags_second_q[5:0] & enable_second_q[5:0]);

  // Decoded write strobes for the two flag registers.
  assign wr_first = reg_wr && (reg_addr == `ADDR_FLAGS_FIRST);
  assign wr_second = reg_wr && (reg_addr == `ADDR_FLAGS_SECOND);

  // ----------------------------------------------------------------
  // Level history for edge detection
  // ----------------------------------------------------------------
  // Remembers the alert levels so only a rise sets the flags.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fifo_high_status_q <= 1'b0;
      fifo_low_status_q <= 1'b0;
    end else begin
      fifo_high_status_q <= fifo_high_status;
      fifo_low_status_q <= fifo_low_status;
    end
  end

  // ----------------------------------------------------------------
  // Flag registers
  // ----------------------------------------------------------------
  // Bit 7 of a write picks set or clear for bits 0 to 6 (0 to 5 in the second register); a hardware
  // event always wins over a clear in the same cycle.
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_flag
      // One bit of the first flag register: event, then host write.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          flags_first_q[gi] <= 1'b0;
        end else if (ev_first[gi]) begin
          flags_first_q[gi] <= 1'b1;
        end else if (wr_first && reg_wdata[gi]) begin
          flags_first_q[gi] <= reg_wdata[`BIT_SET_MODE];
        end
      end
      // One bit of the second flag register; the global bit is hardware only.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          flags_second_q[gi] <= 1'b0;
        end else if (gi == `BIT_ANY_SOURCE) begin
          flags_second_q[gi] <= any_enabled;
        end else if (ev_second[gi]) begin
          flags_second_q[gi] <= 1'b1;
        end else if (wr_second && reg_wdata[gi]) begin
          flags_second_q[gi] <= reg_wdata[`BIT_SET_MODE];
        end
      end
    end
  endgenerate

  // Card detection sits in bit 7 and cannot be reached by the host write.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_first_q[7] <= 1'b0;
      flags_second_q[7] <= 1'b0;
    end else begin
      flags_second_q[7] <= 1'b0;
      if (ev_first[`BIT_CARD_DETECT]) begin
        flags_first_q[7] <= 1'b1;
      end else if (reg_rd && reg_addr == `ADDR_FLAGS_FIRST) begin
        flags_first_q[7] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Enable and threshold registers
  // ----------------------------------------------------------------
  // Plain read/write configuration registers.
  // The extension bit of the threshold lives in the general status address,
  // so a write there only touches that one bit.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_first_q <= `RESET_ENABLE;
      enable_second_q <= `RESET_ENABLE;
      fifo_threshold_q <= `RESET_THRESHOLD;
    end else if (reg_wr) begin
      if (reg_addr == `ADDR_ENABLE_FIRST) begin
        enable_first_q <= reg_wdata;
      end
      if (reg_addr == `ADDR_ENABLE_SECOND) begin
        enable_second_q <= reg_wdata;
      end
      if (reg_addr == `ADDR_FIFO_THRESHOLD) begin
        fifo_threshold_q <= {fifo_threshold_q[8], reg_wdata};
      end
      if (reg_addr == `ADDR_GENERAL_STATUS) begin
        fifo_threshold_q[8] <= reg_wdata[7];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status bit and interrupt pin
  // ----------------------------------------------------------------
  // The status bit is sticky and cleared by a read; a new event wins.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_irq_q <= 1'b0;
    end else if ((|ev_first) || (|ev_second)) begin
      status_irq_q <= 1'b1;
    end else if (reg_rd && reg_addr == `ADDR_GENERAL_STATUS) begin
      status_irq_q <= 1'b0;
    end
  end

  // The pin follows the enabled flags, registered.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= any_enabled |
        (flags_second_q[`BIT_ANY_SOURCE] & enable_second_q[`BIT_ANY_SOURCE]);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Read data stand in the cycle after the strobe; unmapped reads give zero.
  // Between reads the port shows zero, so a stale value is never mistaken
  // for fresh data by the host.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_FLAGS_FIRST: reg_rdata <= flags_first_q;
        `ADDR_FLAGS_SECOND: reg_rdata <= flags_second_q;
        `ADDR_ENABLE_FIRST: reg_rdata <= enable_first_q;
        `ADDR_ENABLE_SECOND: reg_rdata <= enable_second_q;
        `ADDR_GENERAL_STATUS: reg_rdata <= {fifo_threshold_q[8], 4'h0,
          fifo_high_status, fifo_low_status, status_irq_q};
        `ADDR_FIFO_THRESHOLD: reg_rdata <= fifo_threshold_q[7:0];
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // An underflow of timer 0 must show in its flag on the next edge.
  a_timer_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    timer_underflow[0] |=> flags_second_q[0]) else $error("timer flag not set");
  // The transmitter end-of-frame pulse sets the transmit flag.
  a_tx_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    tx_payload_done |=> flags_first_q[0]) else $error("transmit flag not set");
  // Any set error bit sets the error flag.
  a_err_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    (error_bits != 8'h00) |=> flags_first_q[5]) else $error("error flag not set");
  // A clear write removes the written flag when no event collides.
  a_write_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_first && reg_wdata == 8'h02 && !rx_data_end) |=> !flags_first_q[1])
    else $error("flag not cleared");
  // A set write forces the written flag.
  a_write_set: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_first && reg_wdata == 8'h84) |=> flags_first_q[2]) else $error("flag not set");
  // A flag written as zero keeps its value.
  a_zero_keeps: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_first && !reg_wdata[1] && !rx_data_end) |=> $stable(flags_first_q[1]))
    else $error("unwritten flag changed");
  // An enabled set flag raises the pin one edge later.
  a_pin_follows: assert property (@(posedge clk) disable iff (sys_rst)
    (|(flags_first_q & enable_first_q)) |=> irq_out) else $error("pin not raised");
  // A card detection makes the sticky status bit high.
  a_status_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    card_detected |=> status_irq_q) else $error("status bit not set");
  // The global flag follows the enabled sources.
  a_global_flag: assert property (@(posedge clk) disable iff (sys_rst)
    any_enabled |=> flags_second_q[6]) else $error("global flag not set");

  // ----------------------------------------------------------------
  // Further checks on sources, writes and the read port
  // ----------------------------------------------------------------
  // The end of received data sets the receive flag.
  a_rx_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    rx_data_end |=> flags_first_q[1])
    else $error("receive flag not set");

  // A finished command sets the idle flag.
  a_idle_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    command_finished |=> flags_first_q[2])
    else $error("idle flag not set");

  // A frame start sets its flag.
  a_sof_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    rx_frame_start |=> flags_first_q[6])
    else $error("frame start flag not set");

  // A detected card sets the card flag, even during a read.
  a_card_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    card_detected |=> flags_first_q[7])
    else $error("card flag not set");

  // A rise of the high status sets the high-alert flag.
  a_high_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    (fifo_high_status && !fifo_high_status_q) |=> flags_first_q[3])
    else $error("high alert flag not set");

  // A rise of the low status sets the low-alert flag.
  a_low_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    (fifo_low_status && !fifo_low_status_q) |=> flags_first_q[4])
    else $error("low alert flag not set");

  // The last timer underflow sets the last timer flag.
  a_timer3_flag: assert property (@(posedge clk) disable iff (sys_rst)
    timer_underflow[3] |=> flags_second_q[3])
    else $error("last timer flag not set");

  // With nothing enabled and set, the pin falls.
  a_pin_low: assert property (@(posedge clk) disable iff (sys_rst)
    (!any_enabled && !(flags_second_q[6] && enable_second_q[6])) |=> !irq_out)
    else $error("pin not lowered");

  // A clear write to the second register removes the timer flag.
  a_second_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_second && reg_wdata == 8'h01 && !timer_underflow[0]) |=> !flags_second_q[0])
    else $error("second flag not cleared");

  // A set write to the second register forces the timer flag.
  a_second_set: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_second && reg_wdata == 8'h88) |=> flags_second_q[3])
    else $error("second flag not set");

  // An enable write stores the written byte.
  a_enable_write: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `ADDR_ENABLE_FIRST) |=> enable_first_q == $past(reg_wdata))
    else $error("enable not stored");

  // A status read with no event clears the sticky bit.
  a_status_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `ADDR_GENERAL_STATUS && !(|ev_first) && !(|ev_second))
    |=> !status_irq_q) else $error("status bit not cleared");

  // Without a read strobe the read port shows zero.
  a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");

  // The global flag drops once no enabled source is left.
  a_global_clear: assert property (@(posedge clk) disable iff (sys_rst)
    !any_enabled |=> !flags_second_q[6])
    else $error("global flag not cleared");

  // A threshold write stores the low eight bits.
  a_threshold_write: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `ADDR_FIFO_THRESHOLD) |=> fifo_threshold_q[7:0] == $past(reg_wdata))
    else $error("threshold not stored");

  // A timer event also sets the sticky status bit.
  a_event_status: assert property (@(posedge clk) disable iff (sys_rst)
    (|ev_second) |=> status_irq_q)
    else $error("status bit not set by timer");

endmodule : nfc_irq_ctrl

// ===== verification/irq_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Host side of the register port
// ----------------------------------------
// It drives every bus signal right after a rising edge and holds each strobe for one cycle.
module irq_host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // The bus is idle from time zero, so no strobe is seen during reset.
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One write cycle, used to force or clear flags and to set enables.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // One read cycle; the data are taken by the bench in the cycle after it.
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd
endmodule : irq_host_model

// ===== verification/nfc_irq_ctrl_tb.sv
`timescale 1ns/10ps
module nfc_irq_ctrl_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, errb = 8'h00, e0, e1;
  logic reg_wr, reg_rd, irq_out, rd_seen = 1'b0;
  logic [3:0] tmr = 4'h0;
  logic txd = 1'b0, rxd = 1'b0, cmd = 1'b0, card = 1'b0, sof = 1'b0;
  logic [9:0] fill = 10'h064; // Mid level, so neither fill status is raised.
  int err_total = 0, n_checks = 0, cyc = 0, seed;
  irq_ctrl_pkg::reg_byte_t exq[$]; // Expected read data, oldest first.

  nfc_irq_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_underflow(tmr), .tx_payload_done(txd), .rx_data_end(rxd),
    .command_finished(cmd), .fifo_fill(fill), .error_bits(errb),
    .card_detected(card), .rx_frame_start(sof), .irq_out(irq_out));
  irq_host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));

  // The clock toggles every 20 ns, a period of 40 ns.
  initial forever #20 clk = ~clk;

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // Compares one byte result with its expected value.
  task automatic cmp(input irq_ctrl_pkg::reg_byte_t got, input irq_ctrl_pkg::reg_byte_t ex);
    n_checks++;
    if (got !== ex) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, ex);
    end
  endtask : cmp

  // Notes the expected data, then issues the read.
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    exq.push_back(ex);
    u_host.rd(a);
  endtask : rd

  // Pulses one event source for a cycle: 0..2 and 5..7 first register bits, 8..11 timers.
  task automatic ev(input int k);
    @(posedge clk);
    case (k)
      0: txd <= 1'b1;
      1: rxd <= 1'b1;
      2: cmd <= 1'b1;
      5: errb <= 8'($random(seed)) | 8'h01;
      6: sof <= 1'b1;
      7: card <= 1'b1;
      default: tmr[k-8] <= 1'b1;
    endcase
    @(posedge clk);
    {tmr, txd, rxd, cmd, sof, card} <= 9'h000;
    errb <= 8'h00;
  endtask : ev

  // Moves the fill count and lets the status and flag stages settle.
  task automatic setfill(input logic [9:0] v);
    @(posedge clk);
    fill <= v;
    repeat (3) @(posedge clk);
  endtask : setfill

  // Checks the pin once the registered output has followed the flags.
  task automatic irq_is(input logic v);
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp({7'h00, irq_out}, {7'h00, v});
  endtask : irq_is

  // Takes the oldest note whenever read data stand, and cuts a hang short.
  always @(posedge clk) begin
    if (rd_seen) cmp(reg_rdata, exq.pop_front());
    rd_seen <= reg_rd;
    cyc++;
    if (cyc > 4000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    seed = 32'h75d4;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 7; a++) rd(8'(a), (a == 5) ? 8'h08 : 8'h00);
    u_host.wr(8'h06, 8'hff);
    rd(8'h06, 8'h00);
    $display("test reset done");
    e0 = 8'h00;
    e1 = 8'h00;
    for (int k = 0; k < 8; k++) begin
      if (k == 3 || k == 4) continue;
      ev(k);
      e0[k] = 1'b1;
      rd(8'h00, e0);
      e0[7] = 1'b0;
    end
    rd(8'h04, 8'h01);
    rd(8'h04, 8'h00);
    for (int k = 8; k < 12; k++) begin
      ev(k);
      e1[k-8] = 1'b1;
      rd(8'h01, e1);
    end
    setfill(10'd503);
    rd(8'h00, e0);
    setfill(10'd504);
    e0[3] = 1'b1;
    rd(8'h00, e0);
    setfill(10'd9);
    rd(8'h00, e0);
    setfill(10'd8);
    e0[4] = 1'b1;
    rd(8'h00, e0);
    setfill(10'd20 + 10'($random(seed) & 255));
    $display("test events done");
    u_host.wr(8'h00, 8'h7f);
    rd(8'h00, 8'h00);
    u_host.wr(8'h01, 8'h0f);
    rd(8'h01, 8'h00);
    u_host.wr(8'h00, 8'h85);
    rd(8'h00, 8'h05);
    u_host.wr(8'h01, 8'hcf);
    rd(8'h01, 8'h0f);
    u_host.wr(8'h00, 8'h82);
    u_host.wr(8'h00, 8'h01);
    rd(8'h00, 8'h06);
    $display("test host writes done");
    irq_is(1'b0);
    u_host.wr(8'h02, 8'h02);
    irq_is(1'b1);
    rd(8'h02, 8'h02);
    rd(8'h01, 8'h4f);
    u_host.wr(8'h00, 8'h02);
    irq_is(1'b0);
    u_host.wr(8'h03, 8'h01);
    irq_is(1'b1);
    rd(8'h03, 8'h01);
    u_host.wr(8'h01, 8'h0f);
    irq_is(1'b0);
    $display("test interrupt pin done");
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule : nfc_irq_ctrl_tb
